/* File: hw/gsf_map.vh */
`ifndef GSF_MAP_VH
`define GSF_MAP_VH

// register offsets, one byte each, multi-byte values big-endian
`define GSF_OFS_DROP_SEL 7'h0b
`define GSF_OFS_ACCEPT_SEL 7'h0c
`define GSF_OFS_FREEZE 7'h0d
`define GSF_OFS_BASE_HI 7'h10
`define GSF_OFS_BASE_LO 7'h11
`define GSF_OFS_MULT_HI 7'h12
`define GSF_OFS_MULT_LO 7'h13
`define GSF_OFS_STAT_HI 7'h20
`define GSF_OFS_STAT_LO 7'h21

// reset values
`define GSF_RST_DROP_SEL 8'haa
`define GSF_RST_ACCEPT_SEL 8'h55
`define GSF_RST_FREEZE 8'h00
`define GSF_RST_BASE 16'h9c40
`define GSF_RST_MULT 16'h0f30

// freeze control codes
`define GSF_FREEZE_ON 8'h01
`define GSF_FREEZE_OFF 8'h00

// base rate limits in hertz
`define GSF_BASE_MIN 16'h03e8
`define GSF_BASE_MAX 16'h9c40

// delay select codes
`define GSF_DROP_MIN 2'h0
`define GSF_DROP_10MS 2'h1
`define GSF_DROP_50MS 2'h2
`define GSF_DROP_2S5 2'h3

// field layout of the latched status, per input i at bit 4*i
`define GSF_ST_LOSS 0
`define GSF_ST_SINGLE 1
`define GSF_ST_COARSE 2
`define GSF_ST_SOAK 3

// timing: clock rate in mhz, minimum delay in cycles, other delays in microseconds
`define GSF_CLK_MHZ 200
`define GSF_DROP_MIN_CYC 32'h1
`define GSF_DROP_10MS_US 10000
`define GSF_DROP_50MS_US 50000
`define GSF_DROP_2S5_US 2500000

`endif

/* File: hw/gsf_spi_port.v */
`timescale 1ns/1ps
// serial management slave, mode 0, msb first
// first byte: bit 7 read(1)/write(0), bits 6:0 start address
// following bytes: data, address increments after each byte
module gsf_spi_port (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // serial pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso,
    output reg spi_miso_oe,
    // register side
    output reg [6:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_wr,
    output reg reg_rd,
    input wire [7:0] reg_rdata
);

    reg [1:0] sck_s;
    reg [1:0] cs_s;
    reg [1:0] mosi_s;
    reg sck_d;
    reg [2:0] bit_cnt;
    reg [6:0] shift;
    reg [7:0] tx;
    reg in_cmd;
    reg is_read;
    reg load;
    reg inc;
    wire rise;
    wire fall;

    // pins come from the host clock, so two flops before any use
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_s <= 2'h0;
            cs_s <= 2'h3;
            mosi_s <= 2'h0;
            sck_d <= 1'b0;
        end else begin
            sck_s <= {sck_s[0], spi_sck};
            cs_s <= {cs_s[0], spi_cs_n};
            mosi_s <= {mosi_s[0], spi_mosi};
            sck_d <= sck_s[1];
        end
    end

    assign rise = sck_s[1] & ~sck_d;
    assign fall = ~sck_s[1] & sck_d;

    // byte engine; sck must be at most sys_clk / 8 for the sync delay
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 3'h0;
            shift <= 7'h00;
            tx <= 8'h00;
            in_cmd <= 1'b1;
            is_read <= 1'b0;
            load <= 1'b0;
            inc <= 1'b0;
            reg_addr <= 7'h00;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else if (cs_s[1]) begin
            // deselected: abandon any partial byte
            bit_cnt <= 3'h0;
            in_cmd <= 1'b1;
            load <= 1'b0;
            inc <= 1'b0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            inc <= 1'b0;
            spi_miso_oe <= is_read & ~in_cmd;
            // on writes the address moves only after the write strobe was seen
            if (inc) begin
                reg_addr <= reg_addr + 7'h01;
            end
            if (rise) begin
                shift <= {shift[5:0], mosi_s[1]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    if (in_cmd) begin
                        in_cmd <= 1'b0;
                        is_read <= shift[6];
                        reg_addr <= {shift[5:0], mosi_s[1]};
                        load <= shift[6];
                    end else if (is_read) begin
                        reg_addr <= reg_addr + 7'h01;
                        load <= 1'b1;
                    end else begin
                        reg_wdata <= {shift[6:0], mosi_s[1]};
                        reg_wr <= 1'b1;
                        inc <= 1'b1;
                    end
                end
            end
            // shift out on falling sck, except the one closing a byte
            if (fall && bit_cnt != 3'h0) begin
                spi_miso <= tx[7];
                tx <= {tx[6:0], 1'b0};
            end
            // the first bit must sit on miso before the next rising sck
            if (load) begin
                spi_miso <= reg_rdata[7];
                tx <= {reg_rdata[6:0], 1'b0};
                reg_rd <= 1'b1;
                load <= 1'b0;
            end
        end
    end

endmodule

/* File: hw/gsf_guard_regs.v */
`timescale 1ns/1ps
`include "gsf_map.vh"
// Functional notes
// RQ1 - two-bit drop delay per input: 00 min, 01 10 ms, 11 2.5 s
// RQ2 - drop delay runs while coarse or single-cycle fault is present
// RQ3 - drop delay selects reset to 50 ms code, byte 0xaa
// RQ4 - accept delay is 2, 4, 6 or 8 times drop delay; reset 0x55
// RQ5 - accept delay runs only when both faults are absent
// RQ6 - writing 0x01 to freeze control stops latched status updates
// RQ7 - writing 0x00 resumes latched status updates; control resets to 0x00
// RQ8 - input 0 base rate is 16-bit hertz, resets to 0x9c40
// RQ9 - multi-byte registers are big-endian, high byte at lower address
// RQ10 - report loss, single-cycle, coarse and guard-soak per input
// RQ11 - soak sets at drop expiry; clears after uninterrupted accept delay
module gsf_guard_regs #(
    parameter [31:0] DROP_10MS_CYC = `GSF_DROP_10MS_US * `GSF_CLK_MHZ,
    parameter [31:0] DROP_50MS_CYC = `GSF_DROP_50MS_US * `GSF_CLK_MHZ,
    parameter [31:0] DROP_2S5_CYC = `GSF_DROP_2S5_US * `GSF_CLK_MHZ
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // serial management pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    output wire spi_miso,
    output wire spi_miso_oe,
    // fault indicators from the monitors, same clock
    input wire [3:0] clock_loss_fault,
    input wire [3:0] single_cycle_fault,
    input wire [3:0] coarse_freq_fault,
    // results and configuration
    output reg [3:0] guard_soak_fault,
    output reg [15:0] input0_base_rate,
    output reg [15:0] input0_rate_multiplier,
    output reg status_frozen
);

    reg [7:0] guard_disqualify_delay_sel;
    reg [7:0] guard_qualify_delay_sel;
    reg [7:0] status_update_freeze;
    reg [15:0] latched_read_status;
    reg [15:0] next_latched;
    reg [15:0] live_status;
    reg [7:0] rdata;
    reg [31:0] gtimer [0:3];
    wire [6:0] reg_addr;
    wire [7:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [3:0] bad;
    integer i;
    integer k;
    integer j;
    // last count of each delay, per input
    reg [31:0] drop_lim [0:3];
    reg [31:0] accept_lim [0:3];

    // delay length in cycles for a drop select code
    function [31:0] drop_len;
        input [1:0] sel;
        begin
            case (sel)
                `GSF_DROP_MIN: drop_len = `GSF_DROP_MIN_CYC;
                `GSF_DROP_10MS: drop_len = DROP_10MS_CYC;
                `GSF_DROP_50MS: drop_len = DROP_50MS_CYC;
                default: drop_len = DROP_2S5_CYC;
            endcase
        end
    endfunction

    // accept delay: 2, 4, 6 or 8 times the drop delay
    function [31:0] accept_len;
        input [31:0] drop;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: accept_len = {drop[30:0], 1'b0};
                2'h1: accept_len = {drop[29:0], 2'h0};
                2'h2: accept_len = {drop[29:0], 2'h0} + {drop[30:0], 1'b0};
                default: accept_len = {drop[28:0], 3'h0};
            endcase
        end
    endfunction

    gsf_spi_port u_port (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(rdata)
    );

    assign bad = coarse_freq_fault | single_cycle_fault;

    // read mux; unmapped addresses read as zero
    always @* begin
        case (reg_addr)
            `GSF_OFS_DROP_SEL: rdata = guard_disqualify_delay_sel;
            `GSF_OFS_ACCEPT_SEL: rdata = guard_qualify_delay_sel;
            `GSF_OFS_FREEZE: rdata = status_update_freeze;
            `GSF_OFS_BASE_HI: rdata = input0_base_rate[15:8]; // RQ9
            `GSF_OFS_BASE_LO: rdata = input0_base_rate[7:0]; // RQ9
            `GSF_OFS_MULT_HI: rdata = input0_rate_multiplier[15:8];
            `GSF_OFS_MULT_LO: rdata = input0_rate_multiplier[7:0];
            `GSF_OFS_STAT_HI: rdata = latched_read_status[15:8];
            `GSF_OFS_STAT_LO: rdata = latched_read_status[7:0];
            default: rdata = 8'h00;
        endcase
    end

    // register writes; byte-wise, so a 16-bit value takes two writes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_disqualify_delay_sel <= `GSF_RST_DROP_SEL; // RQ3
            guard_qualify_delay_sel <= `GSF_RST_ACCEPT_SEL; // RQ4
            status_update_freeze <= `GSF_RST_FREEZE; // RQ7
            input0_base_rate <= `GSF_RST_BASE; // RQ8
            input0_rate_multiplier <= `GSF_RST_MULT;
            status_frozen <= 1'b0;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `GSF_OFS_DROP_SEL: begin
                        guard_disqualify_delay_sel <= reg_wdata; // RQ1
                    end
                    `GSF_OFS_ACCEPT_SEL: begin
                        guard_qualify_delay_sel <= reg_wdata; // RQ4
                    end
                    `GSF_OFS_FREEZE: begin
                        status_update_freeze <= reg_wdata;
                        // RQ6 RQ7: 0x01 freezes, 0x00 releases, others keep
                        if (reg_wdata == `GSF_FREEZE_ON) begin
                            status_frozen <= 1'b1; // RQ6
                        end else if (reg_wdata == `GSF_FREEZE_OFF) begin
                            status_frozen <= 1'b0; // RQ7
                        end
                    end
                    `GSF_OFS_BASE_HI: begin
                        // high byte sits at the lower address
                        input0_base_rate[15:8] <= reg_wdata; // RQ9
                    end
                    `GSF_OFS_BASE_LO: begin
                        input0_base_rate[7:0] <= reg_wdata; // RQ9
                    end
                    `GSF_OFS_MULT_HI: begin
                        // same byte order as the base rate
                        input0_rate_multiplier[15:8] <= reg_wdata;
                    end
                    `GSF_OFS_MULT_LO: begin
                        input0_rate_multiplier[7:0] <= reg_wdata;
                    end
                    default: begin
                        // status bytes and holes are read-only
                    end
                endcase
            end
        end
    end

    // last count of each delay; selects are read live, so a change made
    // mid-count takes effect at once rather than at the next fault
    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            drop_lim[j] = drop_len(guard_disqualify_delay_sel[2*j +: 2]) -
                32'h1; // RQ1
            accept_lim[j] = accept_len(drop_len(
                guard_disqualify_delay_sel[2*j +: 2]),
                guard_qualify_delay_sel[2*j +: 2]) - 32'h1; // RQ4
        end
    end

    // guard timer per input: one counter serves both delays
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_soak_fault <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                gtimer[i] <= 32'h0;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (!guard_soak_fault[i]) begin
                    if (bad[i]) begin // RQ2
                        // watching: count fault cycles toward the drop
                        if (gtimer[i] >= drop_lim[i]) begin // RQ1
                            guard_soak_fault[i] <= 1'b1; // RQ11
                            gtimer[i] <= 32'h0;
                        end else begin
                            gtimer[i] <= gtimer[i] + 32'h1;
                        end
                    end else begin
                        gtimer[i] <= 32'h0;
                    end
                end else begin
                    // a coarse or single-cycle fault restarts the accept delay from zero
                    if (bad[i]) begin // RQ5
                        gtimer[i] <= 32'h0;
                    end else if (gtimer[i] >= accept_lim[i]) begin // RQ4
                        guard_soak_fault[i] <= 1'b0; // RQ11
                        gtimer[i] <= 32'h0;
                    end else begin
                        gtimer[i] <= gtimer[i] + 32'h1;
                    end
                end
            end
        end
    end

    // latched status: read clears its byte, a new event set wins
    always @* begin
        live_status = 16'h0000;
        for (k = 0; k < 4; k = k + 1) begin
            live_status[4*k + `GSF_ST_LOSS] = clock_loss_fault[k]; // RQ10
            live_status[4*k + `GSF_ST_SINGLE] = single_cycle_fault[k];
            live_status[4*k + `GSF_ST_COARSE] = coarse_freq_fault[k];
            live_status[4*k + `GSF_ST_SOAK] = guard_soak_fault[k];
        end
        next_latched = latched_read_status;
        if (reg_rd && reg_addr == `GSF_OFS_STAT_HI) begin
            next_latched[15:8] = 8'h00;
        end
        if (reg_rd && reg_addr == `GSF_OFS_STAT_LO) begin
            next_latched[7:0] = 8'h00;
        end
        // frozen: new events no longer set bits, but a read still clears its byte
        if (!status_frozen) begin // RQ6 RQ7
            next_latched = next_latched | live_status;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_read_status <= 16'h0000;
        end else begin
            latched_read_status <= next_latched;
        end
    end

endmodule

/* File: verification/gsf_host_model.sv */
`timescale 1ns/1ps
module gsf_host_model (
    // clock
    input wire sys_clk,
    // serial pins
    output reg spi_sck,
    output reg spi_cs_n,
    output reg spi_mosi,
    input wire spi_miso
);
    // half period in clocks, above the 4-cycle minimum for sync margin
    localparam int HALF = 6;
    // idle pins: deselected, clock parked low
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // one byte msb first; miso taken at sck rise, long after it moved
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            @(posedge sys_clk) spi_mosi <= tx[b];
            repeat (HALF) @(posedge sys_clk);
            spi_sck <= 1'b1;
            rx[b] = spi_miso;
            repeat (HALF) @(posedge sys_clk);
            spi_sck <= 1'b0;
        end
    endtask
    // command byte then n data bytes, high byte first
    task automatic frame(input logic rd, input logic [6:0] addr,
        input int n, input logic [15:0] wd, output logic [15:0] rdat);
        logic [7:0] rx;
        rdat = 16'h0000;
        @(posedge sys_clk) spi_cs_n <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
        xfer({rd, addr}, rx);
        for (int k = n - 1; k >= 0; k--) begin
            xfer(wd[8*k +: 8], rx);
            rdat = {rdat[7:0], rx};
        end
        repeat (HALF) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule

/* File: verification/gsf_guard_asserts.sv */
`timescale 1ns/1ps
module gsf_guard_asserts #(
    parameter [31:0] DROP_10MS_CYC = 32'd10,
    parameter [31:0] DROP_50MS_CYC = 32'd50,
    parameter [31:0] DROP_2S5_CYC = 32'd200
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // serial pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire spi_miso,
    input wire spi_miso_oe,
    // faults and results
    input wire [3:0] clock_loss_fault,
    input wire [3:0] single_cycle_fault,
    input wire [3:0] coarse_freq_fault,
    input wire [3:0] guard_soak_fault,
    input wire [15:0] input0_base_rate,
    input wire [15:0] input0_rate_multiplier,
    input wire status_frozen
);
    wire [3:0] bad = coarse_freq_fault | single_cycle_fault;
    // flops are unknown until the first reset edge, so wait one clock
    reg rst_seen = 1'b0;
    always @(posedge sys_clk) begin
        rst_seen <= !rst_n;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // writes land a few cycles after the last bit, inside the frame
    sequence s_bus_idle;
        spi_cs_n [*8];
    endsequence
    a_reset_values: assert property (disable iff (1'b0)
        !rst_n && rst_seen |-> guard_soak_fault == 4'h0 && !status_frozen &&
        input0_base_rate == 16'h9c40 && input0_rate_multiplier == 16'h0f30)
        else $error("reset values wrong");
    a_set_on_bad: assert property (
        (guard_soak_fault & ~$past(guard_soak_fault) & ~$past(bad)) == 4'h0)
        else $error("soak set without fault");
    a_clear_two_clean: assert property (
        (~guard_soak_fault & $past(guard_soak_fault) &
        ($past(bad) | $past(bad, 2))) == 4'h0)
        else $error("soak cleared too soon");
    a_soak_keep_bad: assert property (
        ($past(guard_soak_fault & bad) & ~guard_soak_fault) == 4'h0)
        else $error("soak dropped under fault");
    a_base_bytewise: assert property (
        $changed(input0_base_rate) |->
        $past(input0_base_rate[15:8]) == input0_base_rate[15:8] ||
        $past(input0_base_rate[7:0]) == input0_base_rate[7:0])
        else $error("base changed in both bytes");
    a_base_quiet: assert property (
        s_bus_idle |=> $stable(input0_base_rate) &&
        $stable(input0_rate_multiplier))
        else $error("rate changed outside a frame");
    a_freeze_quiet: assert property (
        s_bus_idle |=> $stable(status_frozen))
        else $error("freeze changed outside a frame");
    a_oe_released: assert property (
        s_bus_idle |-> !spi_miso_oe)
        else $error("miso driven while deselected");
endmodule
bind gsf_guard_regs gsf_guard_asserts #(.DROP_10MS_CYC(DROP_10MS_CYC),
    .DROP_50MS_CYC(DROP_50MS_CYC), .DROP_2S5_CYC(DROP_2S5_CYC))
    gsf_guard_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .clock_loss_fault(clock_loss_fault),
    .single_cycle_fault(single_cycle_fault),
    .coarse_freq_fault(coarse_freq_fault),
    .guard_soak_fault(guard_soak_fault),
    .input0_base_rate(input0_base_rate),
    .input0_rate_multiplier(input0_rate_multiplier),
    .status_frozen(status_frozen));

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, miso_line;
    logic [3:0] clock_loss_fault = 4'h0;
    logic [3:0] single_cycle_fault = 4'h0;
    logic [3:0] coarse_freq_fault = 4'h0;
    wire [3:0] guard_soak_fault;
    wire [15:0] input0_base_rate, input0_rate_multiplier;
    wire status_frozen;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] rd;
    // released miso shows the inverse level, so a stale bit cannot pass
    assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;
    gsf_host_model host_inst (.sys_clk(sys_clk), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));
    // short delay counts: 10, 50 and 200 cycles
    gsf_guard_regs #(.DROP_10MS_CYC(32'd10), .DROP_50MS_CYC(32'd50),
        .DROP_2S5_CYC(32'd200)) gsf_guard_regs_inst (.sys_clk(sys_clk),
        .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .clock_loss_fault(clock_loss_fault),
        .single_cycle_fault(single_cycle_fault),
        .coarse_freq_fault(coarse_freq_fault),
        .guard_soak_fault(guard_soak_fault),
        .input0_base_rate(input0_base_rate),
        .input0_rate_multiplier(input0_rate_multiplier),
        .status_frozen(status_frozen));
    // 200 mhz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // hang guard, far above the expected 9k cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // count cycles until soak of input i reaches lvl
    task automatic wait_soak(input int i, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (guard_soak_fault[i] !== lvl && n < 2000);
    endtask
    task automatic test_reset_values();
        host_inst.frame(1'b1, 7'h0b, 2, 16'h0, rd);
        check("sel bytes", 16'haa55, rd);
        host_inst.frame(1'b1, 7'h0d, 2, 16'h0, rd);
        check("freeze and hole", 16'h0000, rd);
        host_inst.frame(1'b1, 7'h10, 2, 16'h0, rd);
        check("base read", 16'h9c40, rd);
        check("mult port", 16'h0f30, input0_rate_multiplier);
    endtask
    task automatic test_base_write();
        host_inst.frame(1'b0, 7'h10, 2, 16'h03e8, rd);
        check("base port", 16'h03e8, input0_base_rate);
        host_inst.frame(1'b0, 7'h11, 1, 16'h0040, rd);
        check("base low", 16'h0340, input0_base_rate);
        host_inst.frame(1'b1, 7'h10, 2, 16'h0, rd);
        check("base read", 16'h0340, rd);
    endtask
    // input c uses code c for both selects, faults alternate in kind
    task automatic test_guard_timing();
        int d, n;
        for (int c = 0; c < 4; c++) begin
            d = (c == 0) ? 1 : (c == 1) ? 10 : (c == 2) ? 50 : 200;
            host_inst.frame(1'b0, 7'h0b, 2, {4{c[1:0], c[1:0]}}, rd);
            @(posedge sys_clk);
            if (c % 2) begin
                single_cycle_fault[c] <= 1'b1;
            end else begin
                coarse_freq_fault[c] <= 1'b1;
            end
            wait_soak(c, 1'b1, n);
            check("drop cycles", d, n);
            @(posedge sys_clk);
            single_cycle_fault[c] <= 1'b0;
            coarse_freq_fault[c] <= 1'b0;
            wait_soak(c, 1'b0, n);
            check("accept cycles", d * (2 + 2 * c), n);
        end
    endtask
    task automatic test_accept_needs_both();
        int n;
        host_inst.frame(1'b0, 7'h0b, 2, 16'h0000, rd);
        @(posedge sys_clk);
        coarse_freq_fault[1] <= 1'b1;
        single_cycle_fault[1] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        coarse_freq_fault[1] <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check("soak one left", 16'h0002, guard_soak_fault);
        single_cycle_fault[1] <= 1'b0;
        wait_soak(1, 1'b0, n);
        check("accept both", 2, n);
    endtask
    task automatic pulse_loss();
        @(posedge sys_clk);
        clock_loss_fault[0] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        clock_loss_fault[0] <= 1'b0;
    endtask
    // earlier scenarios leave coarse/single plus soak latched per input
    task automatic test_freeze();
        host_inst.frame(1'b1, 7'h20, 2, 16'h0, rd);
        check("status latched", 16'hacec, rd);
        host_inst.frame(1'b1, 7'h20, 2, 16'h0, rd);
        check("status quiet", 16'h0000, rd);
        host_inst.frame(1'b0, 7'h0d, 1, 16'h0001, rd);
        check("frozen", 16'h0001, status_frozen);
        pulse_loss();
        host_inst.frame(1'b1, 7'h21, 1, 16'h0, rd);
        check("status frozen", 16'h0000, rd);
        host_inst.frame(1'b0, 7'h0d, 1, 16'h0000, rd);
        check("thawed", 16'h0000, status_frozen);
        pulse_loss();
        host_inst.frame(1'b1, 7'h21, 1, 16'h0, rd);
        check("loss status", 16'h0001, rd);
    endtask
    // unlisted freeze codes are kept but inert; multiplier is big-endian
    task automatic test_misc_writes();
        host_inst.frame(1'b0, 7'h0d, 1, 16'h0001, rd);
        host_inst.frame(1'b0, 7'h0d, 1, 16'h0002, rd);
        check("freeze kept", 16'h0001, status_frozen);
        host_inst.frame(1'b1, 7'h0d, 1, 16'h0, rd);
        check("freeze byte", 16'h0002, rd);
        host_inst.frame(1'b0, 7'h0d, 1, 16'h0000, rd);
        check("freeze off", 16'h0000, status_frozen);
        host_inst.frame(1'b0, 7'h12, 2, 16'h00c1, rd);
        check("mult port", 16'h00c1, input0_rate_multiplier);
        host_inst.frame(1'b1, 7'h12, 2, 16'h0, rd);
        check("mult read", 16'h00c1, rd);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_reset_values();
        test_base_write();
        test_guard_timing();
        test_accept_needs_both();
        test_freeze();
        test_misc_writes();
        test_done();
    end
endmodule
